// File: design/sid_pkg.sv
// split interrupt descriptor: field layout, reset values, carriers, states
// assumes one 64-bit descriptor word, bit 0 the valid flag
package sid_pkg;

  // descriptor field positions
  localparam int unsigned VALID_BIT   = 0;
  localparam int unsigned REQ_LSB     = 3;
  localparam int unsigned REQ_MSB     = 17;
  localparam int unsigned MPS_LSB     = 18;
  localparam int unsigned MPS_MSB     = 28;
  localparam int unsigned EP_LO_BIT   = 31;
  localparam int unsigned EP_HI_LSB   = 32;
  localparam int unsigned EP_HI_MSB   = 34;
  localparam int unsigned ADDR_LSB    = 35;
  localparam int unsigned ADDR_MSB    = 41;
  localparam int unsigned TOKEN_LSB   = 42;
  localparam int unsigned TOKEN_MSB   = 43;
  localparam int unsigned SPLIT_BIT   = 46;
  localparam int unsigned CERR_LSB    = 55;
  localparam int unsigned CERR_MSB    = 56;

  // token codes
  localparam logic [1:0]  TOKEN_OUT   = 2'h0;
  localparam logic [1:0]  TOKEN_IN    = 2'h1;

  // values after reset
  localparam logic [14:0] REM_RST     = 15'h0000;
  localparam logic [11:0] DONE_RST    = 12'h000;
  localparam logic [1:0]  CERR_RST    = 2'h0;

  // decoded descriptor
  typedef struct packed {
    logic        split;
    logic [1:0]  cerr;
    logic [1:0]  token;
    logic [6:0]  target_function_addr;
    logic [3:0]  endpoint_number;
    logic [10:0] max_packet_bytes;
    logic [14:0] request_byte_count;
  } sid_desc_t;

  // one packet request toward the transaction engine
  typedef struct packed {
    logic        split;
    logic [1:0]  token;
    logic [6:0]  target_function_addr;
    logic [3:0]  endpoint_number;
    logic [10:0] len;
  } sid_pkt_t;

  // status seen by software
  typedef struct packed {
    logic        valid;
    logic [1:0]  cerr;
    logic [11:0] done_byte_count;
  } sid_stat_t;

  typedef enum logic [1:0] {
    SID_IDLE  = 2'h0,
    SID_ISSUE = 2'h1,
    SID_WAIT  = 2'h3,
    SID_DONE  = 2'h2
  } sid_state_t;

endpackage : sid_pkg

// File: design/sid_pkt_len.sv
// packet length limiter: smaller of bytes left and endpoint packet size
// assumes both inputs come from registers on the same clock
`timescale 1ns/1ps
module sid_pkt_len #(
  parameter int unsigned REM_W = 15,
  parameter int unsigned MPS_W = 11
) (
  input  wire logic [REM_W-1:0] remaining,
  input  wire logic [MPS_W-1:0] max_packet_bytes,
  output logic      [MPS_W-1:0] len
);

  // a request shorter than one packet goes out as a short packet
  always_comb begin
    if (remaining < REM_W'(max_packet_bytes)) begin
      len = remaining[MPS_W-1:0];
    end else begin
      len = max_packet_bytes;
    end
  end

endmodule : sid_pkt_len

// File: design/sid_core.sv
// split interrupt descriptor executor: decodes the descriptor that software
// writes and runs it as a sequence of packets, with retries and byte count
// assumes the transaction engine answers each request with one done pulse,
// on the same clock, and that software honours the size limits below
`timescale 1ns/1ps
module sid_core (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               sw_write,
  input  wire logic [63:0]        sw_desc,
  output logic                    pkt_req,
  output sid_pkg::sid_pkt_t       pkt,
  input  wire logic               pkt_done,
  input  wire logic               pkt_err,
  input  wire logic               pkt_fatal,
  input  wire logic [10:0]        pkt_bytes,
  output sid_pkg::sid_stat_t      stat,
  output logic                    desc_done
);

  sid_pkg::sid_state_t state_q, state_d;
  sid_pkg::sid_desc_t  desc_q, desc_d;
  sid_pkg::sid_pkt_t   pkt_q, pkt_d;
  logic                valid_q, valid_d;
  logic [14:0]         rem_q, rem_d;
  logic [11:0]         done_q, done_d;
  logic [10:0]         next_len;
  logic                accept;
  logic [14:0]         rem_left;

  // a write while idle with the valid bit set starts the descriptor
  assign accept = sw_write && (state_q == sid_pkg::SID_IDLE)
                  && sw_desc[sid_pkg::VALID_BIT];
  assign rem_left = 15'(rem_q - {4'h0, pkt_bytes});

  sid_pkt_len #(
    .REM_W (15),
    .MPS_W (11)
  ) u_len (
    .remaining        (rem_q),
    .max_packet_bytes (desc_q.max_packet_bytes),
    .len              (next_len)
  );

  // descriptor sequencing
  always_comb begin
    state_d = state_q;
    desc_d  = desc_q;
    pkt_d   = pkt_q;
    valid_d = valid_q;
    rem_d   = rem_q;
    done_d  = done_q;
    unique case (state_q)
      sid_pkg::SID_IDLE: begin
        if (accept) begin
          desc_d.split = sw_desc[sid_pkg::SPLIT_BIT];
          desc_d.cerr  = sw_desc[sid_pkg::CERR_MSB:sid_pkg::CERR_LSB];
          desc_d.token = sw_desc[sid_pkg::TOKEN_MSB:sid_pkg::TOKEN_LSB];
          desc_d.target_function_addr =
            sw_desc[sid_pkg::ADDR_MSB:sid_pkg::ADDR_LSB];
          desc_d.endpoint_number =
            {sw_desc[sid_pkg::EP_HI_MSB:sid_pkg::EP_HI_LSB],
             sw_desc[sid_pkg::EP_LO_BIT]};
          desc_d.max_packet_bytes =
            sw_desc[sid_pkg::MPS_MSB:sid_pkg::MPS_LSB];
          desc_d.request_byte_count =
            sw_desc[sid_pkg::REQ_MSB:sid_pkg::REQ_LSB];
          rem_d   = sw_desc[sid_pkg::REQ_MSB:sid_pkg::REQ_LSB];
          done_d  = sid_pkg::DONE_RST;
          valid_d = 1'b1;
          state_d = sid_pkg::SID_ISSUE;
        end
      end
      sid_pkg::SID_ISSUE: begin
        pkt_d.split                = desc_q.split;
        pkt_d.token                = desc_q.token;
        pkt_d.target_function_addr = desc_q.target_function_addr;
        pkt_d.endpoint_number      = desc_q.endpoint_number;
        pkt_d.len                  = next_len;
        state_d                    = sid_pkg::SID_WAIT;
      end
      sid_pkg::SID_WAIT: begin
        if (pkt_done) begin
          if (pkt_fatal) begin
            valid_d = 1'b0;
            state_d = sid_pkg::SID_IDLE;
          end else if (pkt_err) begin
            if (desc_q.cerr != 2'h0) begin
              desc_d.cerr = 2'(desc_q.cerr - 2'h1);
              state_d     = sid_pkg::SID_ISSUE;
            end else begin
              state_d = sid_pkg::SID_DONE;
            end
          end else begin
            done_d = 12'(done_q + {1'b0, pkt_bytes});
            rem_d  = rem_left;
            // a short packet or an empty budget ends the descriptor
            if (rem_left == 15'h0000 || pkt_bytes < pkt_q.len) begin
              state_d = sid_pkg::SID_DONE;
            end else begin
              state_d = sid_pkg::SID_ISSUE;
            end
          end
        end
      end
      sid_pkg::SID_DONE: begin
        valid_d = 1'b0;
        state_d = sid_pkg::SID_IDLE;
      end
    endcase
  end

  // state registers; every field resets so pkt and stat read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= sid_pkg::SID_IDLE;
      valid_q <= 1'b0;
      rem_q   <= sid_pkg::REM_RST;
      done_q  <= sid_pkg::DONE_RST;
      desc_q  <= '0;
      pkt_q   <= '0;
    end else begin
      state_q <= state_d;
      valid_q <= valid_d;
      rem_q   <= rem_d;
      done_q  <= done_d;
      desc_q  <= desc_d;
      pkt_q   <= pkt_d;
    end
  end

  // request is a handshake level, the packet fields come from flops
  // the level stands through the done pulse; the engine must not re-fire
  assign pkt_req              = (state_q == sid_pkg::SID_WAIT);
  assign pkt                  = pkt_q;
  assign stat.valid           = valid_q;
  assign stat.cerr            = desc_q.cerr;
  assign stat.done_byte_count = done_q;
  assign desc_done            = (state_q == sid_pkg::SID_DONE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  valid_clear_a: assert property (
    state_q == sid_pkg::SID_DONE |=> !valid_q && state_q == sid_pkg::SID_IDLE)
    else $error("valid flag not cleared after completion");
  fatal_clear_a: assert property (
    state_q == sid_pkg::SID_WAIT && pkt_done && pkt_fatal |=> !valid_q)
    else $error("valid flag kept after fatal error");
  pkt_cap_a: assert property (
    pkt_req |-> pkt.len <= desc_q.max_packet_bytes && pkt.len <= rem_q)
    else $error("packet longer than allowed");
  token_copy_a: assert property (
    pkt_req |-> pkt.token == desc_q.token)
    else $error("packet token differs from descriptor");
  addr_split_a: assert property (
    pkt_req |-> pkt.target_function_addr == desc_q.target_function_addr
      && pkt.split == desc_q.split)
    else $error("packet address or split select wrong");
  ep_join_a: assert property (
    accept |=> desc_q.endpoint_number == {$past(sw_desc[34:32]),
                                          $past(sw_desc[31])})
    else $error("endpoint number assembled wrongly");
  budget_load_a: assert property (
    accept |=> rem_q == $past(sw_desc[17:3]) && valid_q
      ##1 pkt_req)
    else $error("byte budget not loaded or no packet issued");
  retry_a: assert property (
    state_q == sid_pkg::SID_WAIT && pkt_done && !pkt_fatal && pkt_err
      && desc_q.cerr != 2'h0
      |=> desc_q.cerr == 2'($past(desc_q.cerr) - 2'h1)
      ##1 state_q == sid_pkg::SID_WAIT)
    else $error("retry did not decrement error count");
  no_retry_a: assert property (
    state_q == sid_pkg::SID_WAIT && pkt_done && !pkt_fatal && pkt_err
      && desc_q.cerr == 2'h0 |=> state_q == sid_pkg::SID_DONE)
    else $error("retried with error count zero");
  byte_count_a: assert property (
    state_q == sid_pkg::SID_WAIT && pkt_done && !pkt_err && !pkt_fatal
      |=> stat.done_byte_count == 12'($past(done_q) + $past(pkt_bytes)))
    else $error("transferred byte count wrong");
  refuse_idle_a: assert property (
    sw_write && state_q == sid_pkg::SID_IDLE
      && !sw_desc[sid_pkg::VALID_BIT]
      |=> state_q == sid_pkg::SID_IDLE && !valid_q)
    else $error("write without valid bit was started");
  busy_hold_a: assert property (
    sw_write && state_q == sid_pkg::SID_WAIT && !pkt_done
      |=> desc_q == $past(desc_q) && state_q == sid_pkg::SID_WAIT)
    else $error("write while busy changed the descriptor");
  fatal_no_done_a: assert property (
    state_q == sid_pkg::SID_WAIT && pkt_done && pkt_fatal
      |=> !desc_done && state_q == sid_pkg::SID_IDLE)
    else $error("fatal error reported as completion");

  full_run_c: cover property (
    accept ##[3:40] state_q == sid_pkg::SID_DONE);
  retry_c: cover property (
    state_q == sid_pkg::SID_WAIT && pkt_done && pkt_err && !pkt_fatal
      ##[1:4] pkt_done && !pkt_err);
  fatal_c: cover property (
    state_q == sid_pkg::SID_WAIT && pkt_done && pkt_fatal);
  zero_len_c: cover property (
    pkt_req && pkt.len == 11'h000);

endmodule : sid_core

// File: bench/sid_fn_model.sv
// engine and far function model: answers each packet request once
// assumes requests hold until the done pulse, all on one clock
`timescale 1ns/1ps
module sid_fn_model (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              pkt_req,
  input  wire sid_pkg::sid_pkt_t pkt,
  input  wire logic [3:0]        delay,
  input  wire logic [10:0]       short_by,
  input  wire logic              err,
  input  wire logic              fatal,
  output logic                   pkt_done,
  output logic                   pkt_err,
  output logic                   pkt_fatal,
  output logic [10:0]            pkt_bytes
);
  logic [3:0] cnt_q;
  logic       fire;
  // a slow far side waits delay cycles before it answers
  assign fire = !srst && pkt_req && !pkt_done && cnt_q == delay;
  always_ff @(posedge clk) begin
    cnt_q     <= (srst || !pkt_req || pkt_done) ? 4'h0 : cnt_q + 4'h1;
    pkt_done  <= fire;
    // answer fields mean nothing without done, so they toggle meanwhile
    pkt_err   <= fire ? err : !pkt_err;
    pkt_fatal <= fire ? fatal : !pkt_fatal;
    pkt_bytes <= fire ? pkt.len - short_by : ~pkt_bytes;
  end
endmodule : sid_fn_model

// File: bench/split_interrupt_descriptor_fields_bench.sv
// bench for the split descriptor executor: table cases, then hand tests
// assumes sid_core on one 40 MHz clock with synchronous reset
`timescale 1ns/1ps
module split_interrupt_descriptor_fields_bench;
  typedef struct packed {
    logic s; logic [1:0] t; logic [6:0] a;
    logic [3:0] e; logic [10:0] m; logic [14:0] r;
  } sid_row_t;
  logic               clk, srst, sw_write, pkt_req, pkt_done;
  logic               pkt_err, pkt_fatal, desc_done, m_err, m_fatal;
  logic [63:0]        sw_desc;
  logic [10:0]        pkt_bytes, m_short;
  logic [3:0]         m_delay;
  sid_pkg::sid_pkt_t  pkt;
  sid_pkg::sid_stat_t stat;
  int                 errors, comparisons;
  // sizes within limits: packets up to 64 bytes, budgets under 4 kB
  sid_row_t rows [4] = '{
    '{1'b1, 2'h0, 7'h05, 4'h3, 11'h040, 15'h0080},
    '{1'b1, 2'h1, 7'h7f, 4'hf, 11'h008, 15'h0014},
    '{1'b0, 2'h1, 7'h00, 4'h8, 11'h040, 15'h0000},
    '{1'b1, 2'h0, 7'h2a, 4'h1, 11'h001, 15'h0003}};

  sid_core u_dut (.clk, .srst, .sw_write, .sw_desc, .pkt_req, .pkt,
    .pkt_done, .pkt_err, .pkt_fatal, .pkt_bytes, .stat, .desc_done);
  sid_fn_model u_fn (.clk, .srst, .pkt_req, .pkt, .delay(m_delay),
    .short_by(m_short), .err(m_err), .fatal(m_fatal), .pkt_done,
    .pkt_err, .pkt_fatal, .pkt_bytes);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // reserved bits 1, 2, 29 and 30 written as ones, so decoding must skip them
  function automatic logic [63:0] mk(sid_row_t w, logic [1:0] ce);
    mk = 64'h0000_0000_6000_0007;
    mk[46] = w.s;
    mk[43:42] = w.t;
    mk[41:35] = w.a;
    mk[34:31] = w.e;
    mk[28:18] = w.m;
    mk[17:3] = w.r;
    mk[56:55] = ce;
  endfunction : mk

  task automatic report_and_stop;
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(logic [63:0] seen, logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t seen %0h want %0h", $time, seen, want);
    end
  endtask : chk

  // sel 0 waits for a request, 1 for the answer
  task automatic wait_hi(int sel);
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      if ((sel == 0 ? pkt_req : pkt_done) === 1'b1) return;
    end
    errors++;
    report_and_stop();
  endtask : wait_hi

  // descriptor word is scrambled after the strobe to catch no latching
  task automatic put(logic [63:0] d);
    @(negedge clk);
    sw_write = 1'b1;
    sw_desc = d;
    @(negedge clk);
    sw_write = 1'b0;
    sw_desc = ~d;
  endtask : put

  task automatic run(sid_row_t w);
    logic [14:0] rem;
    logic [11:0] tot;
    logic [10:0] ln;
    rem = w.r;
    tot = 12'h000;
    put(mk(w, 2'h0));
    do begin
      ln = (rem < 15'(w.m)) ? rem[10:0] : w.m;
      wait_hi(0);
      chk(pkt, {w.s, w.t, w.a, w.e, ln});
      wait_hi(1);
      rem = rem - 15'(ln);
      tot = tot + 12'(ln);
    end while (rem != 15'h0);
    @(negedge clk);
    chk(desc_done, 1'b1);
    chk(stat.done_byte_count, tot);
    @(negedge clk);
    chk(stat.valid, 1'b0);
  endtask : run

  initial begin
    errors = 0;
    comparisons = 0;
    {sw_write, sw_desc, m_delay, m_short, m_err, m_fatal} = '0;
    srst = 1'b1;
    repeat (16) @(negedge clk);
    chk(stat, 15'h0);
    chk(pkt_req, 1'b0);
    srst = 1'b0;
    put(mk(rows[0], 2'h0) & ~64'h1);
    repeat (3) @(negedge clk);
    chk(pkt_req, 1'b0);
    foreach (rows[i]) begin
      m_delay = 4'(i * 3);
      run(rows[i]);
    end
    // second write while busy is dropped; short packet ends early
    m_short = 11'h003;
    put(mk(rows[0], 2'h0));
    put(mk(rows[1], 2'h0));
    wait_hi(0);
    chk(pkt, {1'b1, 2'h0, 7'h05, 4'h3, 11'h040});
    wait_hi(1);
    m_short = 11'h000;
    @(negedge clk);
    chk(desc_done, 1'b1);
    chk(stat.done_byte_count, 12'h03d);
    @(negedge clk);
    // retry then fatal error
    m_err = 1'b1;
    put(mk(rows[1], 2'h2));
    wait_hi(1);
    m_err = 1'b0;
    @(negedge clk);
    chk(stat.cerr, 2'h1);
    wait_hi(0);
    chk(pkt.len, 11'h008);
    m_fatal = 1'b1;
    wait_hi(1);
    m_fatal = 1'b0;
    @(negedge clk);
    chk({stat.valid, desc_done}, 2'h0);
    // error with no retries left ends the descriptor
    m_err = 1'b1;
    put(mk(rows[2], 2'h0));
    wait_hi(1);
    m_err = 1'b0;
    @(negedge clk);
    chk(desc_done, 1'b1);
    @(negedge clk);
    chk(stat.valid, 1'b0);
    report_and_stop();
  end
endmodule : split_interrupt_descriptor_fields_bench
